// file: src/tor_defs.svh
/*
  Register offsets, reset values and codes for the terminal override and relay map block.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef TOR_DEFS_SVH
`define TOR_DEFS_SVH

`define TOR_ADDR_W           8
`define TOR_OFS_FREQ_SRC     8'h00
`define TOR_OFS_RUN_SRC      8'h04
`define TOR_OFS_SLOT_BASE    8'h10
`define TOR_OFS_SLOT_LAST    8'h24
`define TOR_OFS_OUT11_FUNC   8'h28
`define TOR_OFS_OUT12_FUNC   8'h2c
`define TOR_OFS_RELAY_FUNC   8'h30
`define TOR_OFS_RELAY_POL    8'h34
`define TOR_OFS_STATUS       8'h38

`define TOR_NUM_SLOTS        6
`define TOR_NUM_FUNCS        16
`define TOR_CODE_FORCE_TERM  8'h33
`define TOR_SRC_TERMINAL     8'h01
`define TOR_FUNC_RUN         8'h00
`define TOR_FUNC_ALARM       8'h05
`define TOR_POL_DIRECT       1'h0
`define TOR_POL_INVERT       1'h1

`define TOR_RST_FREQ_SRC     8'h02
`define TOR_RST_RUN_SRC      8'h02
`define TOR_RST_SLOT         8'h00
`define TOR_RST_OUT11_FUNC   8'h00
`define TOR_RST_OUT12_FUNC   8'h00
`define TOR_RST_RELAY_FUNC   `TOR_FUNC_ALARM
`define TOR_RST_RELAY_POL    `TOR_POL_INVERT

`endif

// file: src/tor_pkg.sv
/*
  Types for the terminal override and relay map block.
  Assumes the constants header is included by the design files that use its macros; this package and the synchroniser do not include it.
*/
package tor_pkg;
    typedef enum logic [0:0] {TOR_ST_IDLE, TOR_ST_STOPPING} tor_ovr_state_t;
    typedef logic [7:0] tor_code_t;
endpackage

// file: src/tor_sync.sv
/*
  Two-stage synchroniser for a group of terminal inputs, one stage pair per bit.
  Assumes ref_clk and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module tor_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                stage1_r[i] <= 1'b0;
                syncOut[i]  <= 1'b0;
            end
            else
            begin
                stage1_r[i] <= rawIn[i];
                syncOut[i]  <= stage1_r[i];
            end
        end
    end
endmodule

// file: src/tor_terminal_override_relay.sv
/*
  Terminal source override and output function map with alarm relay, APB slave.
  Assumes synchronous APB master on ref_clk; motorRunning and function signals synchronous.
*/
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "tor_defs.svh"

module tor_terminal_override_relay (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  termIn,
    input  wire logic        motorRunning,
    input  wire logic [15:0] funcSig,
    output logic [7:0]       freqSrcEff,
    output logic [7:0]       runSrcEff,
    output logic             stopRequest,
    output logic             oc11On,
    output logic             oc12On,
    output logic             relayCoil
);
    logic [5:0]           termSync;
    logic                 overrideReq;
    tor_pkg::tor_code_t   freqSrcSel_r, freqSrcSel_nxt;
    tor_pkg::tor_code_t   runSrcSel_r, runSrcSel_nxt;
    tor_pkg::tor_code_t   slotFunc_r [`TOR_NUM_SLOTS];
    tor_pkg::tor_code_t   slotFunc_nxt [`TOR_NUM_SLOTS];
    tor_pkg::tor_code_t   out11Func_r, out11Func_nxt;
    tor_pkg::tor_code_t   out12Func_r, out12Func_nxt;
    tor_pkg::tor_code_t   relayFunc_r, relayFunc_nxt;
    logic                 relayPol_r, relayPol_nxt;
    logic [31:0]          prdata_nxt;
    logic                 pready_nxt, pslverr_nxt;
    logic                 wrEn;
    tor_pkg::tor_ovr_state_t state_r, state_nxt;
    logic                 applied_r, applied_nxt;
    logic                 stop_nxt;
    logic [7:0]           freqEff_nxt, runEff_nxt;
    logic                 oc11_nxt, oc12_nxt, coil_nxt;

    tor_sync #(.WIDTH(`TOR_NUM_SLOTS)) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .rawIn   (termIn),
        .syncOut (termSync)
    );

    // override request from any slot coded as force-terminal, synchronised inputs only
    always_comb
    begin
        overrideReq = 1'b0;
        for (int i = 0; i < `TOR_NUM_SLOTS; i++)
            if (slotFunc_r[i] == `TOR_CODE_FORCE_TERM && termSync[i])
                overrideReq = 1'b1;
    end

    // function signal picked by an 8-bit code; codes out of range read as off
    function automatic logic pickFunc(input logic [7:0] code, input logic [15:0] sig);
        pickFunc = (code < 8'h10) ? sig[code[3:0]] : 1'b0;
    endfunction

    // apb: setup cycle arms pready, access cycle completes with zero wait
    assign wrEn = psel && penable && pready && pwrite && !pslverr;

    always_comb
    begin
        freqSrcSel_nxt = freqSrcSel_r;
        runSrcSel_nxt  = runSrcSel_r;
        slotFunc_nxt   = slotFunc_r;
        out11Func_nxt  = out11Func_r;
        out12Func_nxt  = out12Func_r;
        relayFunc_nxt  = relayFunc_r;
        relayPol_nxt   = relayPol_r;
        pready_nxt     = psel && !penable;
        pslverr_nxt    = 1'b0;
        prdata_nxt     = 32'h0;
        if (psel && !penable)
        begin
            if (paddr[1:0] != 2'h0)
                pslverr_nxt = 1'b1;
            else if (paddr >= `TOR_OFS_SLOT_BASE && paddr <= `TOR_OFS_SLOT_LAST)
                prdata_nxt = {24'h0, slotFunc_r[3'((paddr - `TOR_OFS_SLOT_BASE) >> 2)]};
            else
                unique case (paddr)
                    `TOR_OFS_FREQ_SRC:   prdata_nxt = {24'h0, freqSrcSel_r};
                    `TOR_OFS_RUN_SRC:    prdata_nxt = {24'h0, runSrcSel_r};
                    `TOR_OFS_OUT11_FUNC: prdata_nxt = {24'h0, out11Func_r};
                    `TOR_OFS_OUT12_FUNC: prdata_nxt = {24'h0, out12Func_r};
                    `TOR_OFS_RELAY_FUNC: prdata_nxt = {24'h0, relayFunc_r};
                    `TOR_OFS_RELAY_POL:  prdata_nxt = {31'h0, relayPol_r};
                    `TOR_OFS_STATUS:
                        prdata_nxt = {24'h0, relayCoil, oc12On, oc11On, stopRequest,
                                      overrideReq, applied_r, motorRunning, 1'b0};
                    default:             pslverr_nxt = 1'b1;
                endcase
            if (pwrite && paddr == `TOR_OFS_STATUS)
                pslverr_nxt = 1'b1;
        end
        if (wrEn)
        begin
            if (paddr >= `TOR_OFS_SLOT_BASE && paddr <= `TOR_OFS_SLOT_LAST)
                slotFunc_nxt[3'((paddr - `TOR_OFS_SLOT_BASE) >> 2)] = pwdata[7:0];
            else
                unique case (paddr)
                    `TOR_OFS_FREQ_SRC:   freqSrcSel_nxt = pwdata[7:0];
                    `TOR_OFS_RUN_SRC:    runSrcSel_nxt  = pwdata[7:0];
                    `TOR_OFS_OUT11_FUNC: out11Func_nxt  = pwdata[7:0];
                    `TOR_OFS_OUT12_FUNC: out12Func_nxt  = pwdata[7:0];
                    `TOR_OFS_RELAY_FUNC: relayFunc_nxt  = pwdata[7:0];
                    `TOR_OFS_RELAY_POL:  relayPol_nxt   = pwdata[0];
                    default:             ;
                endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            freqSrcSel_r <= `TOR_RST_FREQ_SRC;
            runSrcSel_r  <= `TOR_RST_RUN_SRC;
            for (int i = 0; i < `TOR_NUM_SLOTS; i++)
                slotFunc_r[i] <= `TOR_RST_SLOT;
            out11Func_r  <= `TOR_RST_OUT11_FUNC;
            out12Func_r  <= `TOR_RST_OUT12_FUNC;
            relayFunc_r  <= `TOR_RST_RELAY_FUNC;
            relayPol_r   <= `TOR_RST_RELAY_POL;
            prdata       <= 32'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end
        else
        begin
            freqSrcSel_r <= freqSrcSel_nxt;
            runSrcSel_r  <= runSrcSel_nxt;
            slotFunc_r   <= slotFunc_nxt;
            out11Func_r  <= out11Func_nxt;
            out12Func_r  <= out12Func_nxt;
            relayFunc_r  <= relayFunc_nxt;
            relayPol_r   <= relayPol_nxt;
            prdata       <= prdata_nxt;
            pready       <= pready_nxt;
            pslverr      <= pslverr_nxt;
        end
    end

    // override switching: a change while running holds stop until the motor halts
    always_comb
    begin
        state_nxt   = state_r;
        applied_nxt = applied_r;
        stop_nxt    = 1'b0;
        unique case (state_r)
            tor_pkg::TOR_ST_IDLE:
                if (overrideReq != applied_r)
                begin
                    if (motorRunning)
                    begin
                        state_nxt = tor_pkg::TOR_ST_STOPPING;
                        stop_nxt  = 1'b1;
                    end
                    else
                        applied_nxt = overrideReq;
                end
            tor_pkg::TOR_ST_STOPPING:
                if (overrideReq == applied_r)
                    state_nxt = tor_pkg::TOR_ST_IDLE;
                else if (motorRunning)
                    stop_nxt = 1'b1;
                else
                begin
                    applied_nxt = overrideReq;
                    state_nxt   = tor_pkg::TOR_ST_IDLE;
                end
        endcase
        freqEff_nxt = applied_r ? `TOR_SRC_TERMINAL : freqSrcSel_r;
        runEff_nxt  = applied_r ? `TOR_SRC_TERMINAL : runSrcSel_r;
        oc11_nxt    = pickFunc(out11Func_r, funcSig);
        oc12_nxt    = pickFunc(out12Func_r, funcSig);
        coil_nxt    = pickFunc(relayFunc_r, funcSig) ^ relayPol_r;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r     <= tor_pkg::TOR_ST_IDLE;
            applied_r   <= 1'b0;
            stopRequest <= 1'b0;
            freqSrcEff  <= `TOR_RST_FREQ_SRC;
            runSrcEff   <= `TOR_RST_RUN_SRC;
            oc11On      <= 1'b0;
            oc12On      <= 1'b0;
            relayCoil   <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            applied_r   <= applied_nxt;
            stopRequest <= stop_nxt;
            freqSrcEff  <= freqEff_nxt;
            runSrcEff   <= runEff_nxt;
            oc11On      <= oc11_nxt;
            oc12On      <= oc12_nxt;
            relayCoil   <= coil_nxt;
        end
    end

    sequence seqChangeWhileRunning;
        (overrideReq != applied_r) && motorRunning;
    endsequence

    sequence seqStopHeld;
        stopRequest && applied_r == $past(applied_r);
    endsequence

    AST_FORCED_SOURCES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        applied_r |=> freqSrcEff == 8'h01 && runSrcEff == 8'h01)
        else $error("sources not forced to terminals");

    AST_USER_SOURCES: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !applied_r |=> freqSrcEff == $past(freqSrcSel_r) && runSrcEff == $past(runSrcSel_r))
        else $error("configured sources not restored");

    AST_STOP_BEFORE_SWITCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seqChangeWhileRunning |=> seqStopHeld)
        else $error("switch without stop while running");

    AST_SWITCH_ONLY_STOPPED: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(applied_r) |-> !$past(motorRunning))
        else $error("source switched while motor running");

    AST_OC_MAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        out11Func_r < 8'h10 |=> oc11On == $past(funcSig[out11Func_r[3:0]]))
        else $error("terminal 11 does not follow its function");

    AST_ALARM_ON_12: assert property (@(posedge ref_clk) disable iff (!reset_n)
        out12Func_r == 8'h05 |=> oc12On == $past(funcSig[5]))
        else $error("alarm not on terminal 12");

    // sampled reset_n keeps the release edge out, the coil still shows its reset value there
    AST_COIL_POLARITY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reset_n && relayFunc_r < 8'h10
        |=> relayCoil == ($past(funcSig[relayFunc_r[3:0]]) ^ $past(relayPol_r)))
        else $error("relay coil polarity wrong");

    AST_RELAY_DEFAULTS: assert property (@(posedge ref_clk)
        $rose(reset_n) |-> relayFunc_r == 8'h05 && relayPol_r == 1'b1)
        else $error("relay defaults wrong after reset");

    AST_SYNC_DELAY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        termSync == $past(termIn, 2))
        else $error("terminal synchroniser latency wrong");
endmodule

// file: verification/tor_motor_model.sv
/*
  Far-side model: motor drive that obeys the stop request, and terminal wiring.
  Assumes ref_clk and active-low reset of the block; bench supplies commands.
*/
`timescale 1ns/1ps

module tor_motor_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       runCmd,
    input  wire logic [3:0] stopLag,
    input  wire logic [5:0] termCmd,
    input  wire logic       stopRequest,
    output logic            motorRunning,
    output logic      [5:0] termIn
);
    logic       run_r;
    logic       run_nxt;
    logic [3:0] lag_r;
    logic [3:0] lag_nxt;
    logic [5:0] term_r;
    logic [5:0] term_nxt;

    always_comb
    begin
        run_nxt  = run_r;
        lag_nxt  = lag_r;
        term_nxt = termCmd;
        // coasts for stopLag cycles, then stays stopped until the request drops
        if (stopRequest)
        begin
            if (lag_r >= stopLag)
                run_nxt = 1'b0;
            else
                lag_nxt = lag_r + 4'h1;
        end
        else
        begin
            run_nxt = runCmd;
            lag_nxt = 4'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_r  <= 1'b0;
            lag_r  <= 4'h0;
            term_r <= 6'h00;
        end
        else
        begin
            run_r  <= run_nxt;
            lag_r  <= lag_nxt;
            term_r <= term_nxt;
        end
    end

    assign motorRunning = run_r;
    assign termIn       = term_r;
endmodule

// file: verification/tb.sv
/*
  Self-checking bench for the override and relay map block.
  Assumes the design header, package and modules compile first.
*/
`timescale 1ns/1ps
`include "tor_defs.svh"

module tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [5:0]  termCmd = 6'h00;
    logic        runCmd  = 1'b0;
    logic [3:0]  stopLag = 4'h0;
    logic [15:0] funcSig = 16'h0000;
    logic [31:0] prdata;
    logic [5:0]  termIn;
    logic [7:0]  freqSrcEff;
    logic [7:0]  runSrcEff;
    logic        pready, pslverr, motorRunning, stopRequest, oc11On, oc12On, relayCoil;
    int          failCount  = 0;
    int          checkCount = 0;

    always #5 ref_clk = ~ref_clk;

    tor_terminal_override_relay DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .termIn(termIn), .motorRunning(motorRunning),
        .funcSig(funcSig), .freqSrcEff(freqSrcEff), .runSrcEff(runSrcEff),
        .stopRequest(stopRequest), .oc11On(oc11On), .oc12On(oc12On), .relayCoil(relayCoil));

    tor_motor_model motor (.ref_clk(ref_clk), .reset_n(reset_n), .runCmd(runCmd),
        .stopLag(stopLag), .termCmd(termCmd), .stopRequest(stopRequest),
        .motorRunning(motorRunning), .termIn(termIn));

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp)
        begin
            failCount++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic errExp, input logic [31:0] rdExp);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // waits for the slave; only the watchdog ends a hang
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        chk({31'h0, pslverr}, {31'h0, errExp}, "slave error");
        if (!wr)
            chk(prdata, rdExp, "read data");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset();
        apb(1'b0, `TOR_OFS_FREQ_SRC, 32'h0, 1'b0, 32'h02);
        apb(1'b0, `TOR_OFS_RUN_SRC, 32'h0, 1'b0, 32'h02);
        apb(1'b0, `TOR_OFS_SLOT_LAST, 32'h0, 1'b0, 32'h00);
        apb(1'b0, `TOR_OFS_OUT11_FUNC, 32'h0, 1'b0, 32'h00);
        apb(1'b0, `TOR_OFS_RELAY_FUNC, 32'h0, 1'b0, 32'h05);
        apb(1'b0, `TOR_OFS_RELAY_POL, 32'h0, 1'b0, 32'h01);
        apb(1'b0, 8'h3c, 32'h0, 1'b1, 32'h00);
        apb(1'b1, `TOR_OFS_STATUS, 32'hff, 1'b1, 32'h0);
        funcSig <= 16'h0000;
        cyc(3);
        chk({31'h0, relayCoil}, 32'h1, "coil alarm off");
        funcSig <= 16'h0020;
        cyc(3);
        chk({31'h0, relayCoil}, 32'h0, "coil alarm on");
        $display("test reset and default relay done");
    endtask

    task automatic t_relay_map();
        apb(1'b1, `TOR_OFS_OUT11_FUNC, 32'h05, 1'b0, 32'h0);
        apb(1'b1, `TOR_OFS_RELAY_POL, 32'h00, 1'b0, 32'h0);
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, `TOR_OFS_RELAY_FUNC, 32'(c), 1'b0, 32'h0);
            funcSig <= 16'h0001 << c;
            cyc(3);
            chk({31'h0, relayCoil}, 32'h1, "relay follows");
            chk({31'h0, oc11On}, 32'(c == 5), "out11 alarm");
            chk({31'h0, oc12On}, 32'(c == 0), "out12 run");
            funcSig <= ~(16'h0001 << c);
            cyc(3);
            chk({31'h0, relayCoil}, 32'h0, "relay off");
        end
        apb(1'b1, `TOR_OFS_RELAY_FUNC, 32'h00, 1'b0, 32'h0);
        apb(1'b1, `TOR_OFS_RELAY_POL, 32'h01, 1'b0, 32'h0);
        apb(1'b1, `TOR_OFS_OUT12_FUNC, 32'h05, 1'b0, 32'h0);
        funcSig <= 16'h0001;
        cyc(3);
        chk({31'h0, relayCoil}, 32'h0, "inverted run on");
        chk({31'h0, oc12On}, 32'h0, "out12 alarm off");
        funcSig <= 16'h0020;
        cyc(3);
        chk({31'h0, relayCoil}, 32'h1, "inverted run off");
        chk({31'h0, oc12On}, 32'h1, "out12 alarm on");
        $display("test relay map done");
    endtask

    task automatic t_override_idle();
        apb(1'b1, `TOR_OFS_FREQ_SRC, 32'h03, 1'b0, 32'h0);
        apb(1'b1, `TOR_OFS_RUN_SRC, 32'h04, 1'b0, 32'h0);
        apb(1'b1, 8'h18, 32'h33, 1'b0, 32'h0);
        termCmd <= 6'h04;
        cyc(8);
        chk({24'h0, freqSrcEff}, 32'h01, "forced freq");
        chk({24'h0, runSrcEff}, 32'h01, "forced run");
        chk({31'h0, stopRequest}, 32'h0, "no stop idle");
        apb(1'b0, `TOR_OFS_STATUS, 32'h0, 1'b0, 32'hec);
        termCmd <= 6'h00;
        cyc(8);
        chk({24'h0, freqSrcEff}, 32'h03, "user freq");
        chk({24'h0, runSrcEff}, 32'h04, "user run");
        $display("test override idle done");
    endtask

    task automatic ovr_run(input logic [5:0] t, input logic [3:0] lag,
                           input logic [7:0] oldF, input logic [7:0] newF);
        int n;
        stopLag <= lag;
        termCmd <= t;
        n = 0;
        while (stopRequest !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk({31'h0, stopRequest}, 32'h1, "stop raised");
        n = 0;
        while (stopRequest !== 1'b0 && n < 40)
        begin
            if (motorRunning === 1'b1)
                chk({24'h0, freqSrcEff}, {24'h0, oldF}, "switched early");
            @(posedge ref_clk);
            n++;
        end
        chk({31'h0, stopRequest}, 32'h0, "stop released");
        cyc(3);
        chk({24'h0, freqSrcEff}, {24'h0, newF}, "switched after stop");
    endtask

    task automatic t_override_run();
        runCmd <= 1'b1;
        cyc(4);
        ovr_run(6'h04, 4'h6, 8'h03, 8'h01);
        cyc(4);
        ovr_run(6'h00, 4'h1, 8'h01, 8'h03);
        runCmd <= 1'b0;
        $display("test override running done");
    endtask

    // reset in mid-run must bring back the relay and frequency source defaults
    task automatic t_mid_reset();
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        apb(1'b0, `TOR_OFS_RELAY_FUNC, 32'h0, 1'b0, 32'h05);
        apb(1'b0, `TOR_OFS_RELAY_POL, 32'h0, 1'b0, 32'h01);
        apb(1'b0, `TOR_OFS_FREQ_SRC, 32'h0, 1'b0, 32'h02);
        cyc(2);
        chk({24'h0, freqSrcEff}, 32'h02, "freq after reset");
        chk({31'h0, relayCoil}, 32'h0, "coil alarm on after reset");
        $display("test mid-run reset done");
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failCount++;
        $display("BAD %0t watchdog expired", $time);
        giveVerdict();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_relay_map();
        t_override_idle();
        t_override_run();
        t_mid_reset();
        giveVerdict();
    end
endmodule
